// [epi_pkg.sv]
// package of register map, field positions and reset values for the pin irq
package epi_pkg;
  localparam logic [7:0]  ADDR_W           = 8'h08;
  // register byte offsets
  localparam logic [7:0]  OFF_STATUS_CTRL  = 8'h00;
  localparam logic [7:0]  OFF_BREAK_CTRL   = 8'h04;
  localparam logic [7:0]  OFF_IRQ_STATUS   = 8'h08;
  localparam logic [7:0]  OFF_IRQ_MASK     = 8'h0c;
  localparam logic [7:0]  OFF_PIN_LEVEL    = 8'h10;
  localparam logic [7:0]  OFF_VECTOR       = 8'h14;
  // pin_int_status_control field positions
  localparam int          BIT_MODE         = 0;
  localparam int          BIT_MASK         = 1;
  localparam int          BIT_ACK          = 2;
  localparam int          BIT_PEND         = 3;
  // break_flag_control_reg field position
  localparam int          BIT_BREAK_CLEAR_ENABLE         = 7;
  // event status bits
  localparam int          EV_LATCH         = 0;
  localparam int          EV_FETCH         = 1;
  // reset values
  localparam logic        RST_MODE         = 1'b0;
  localparam logic        RST_MASK         = 1'b0;
  localparam logic        RST_BREAK_CLEAR_ENABLE         = 1'b0;
  localparam logic [1:0]  RST_EV           = 2'h0;
  // vector location fetched when the request is taken
  localparam logic [15:0] VEC_HI_ADDR      = 16'hfffa;
  localparam logic [15:0] VEC_LO_ADDR      = 16'hfffb;
  // axi response codes
  localparam logic [1:0]  RESP_OKAY        = 2'h0;
  localparam logic [1:0]  RESP_SLVERR      = 2'h2;
endpackage

// [epi_latch.sv]
// request latch with edge or edge-and-level sensitivity
`timescale 1ns/1ns
module epi_latch (
  input  wire logic sys_clk,
  input  wire logic reset,
  input  wire logic pin_n,
  input  wire logic level_mode,
  input  wire logic ack,
  output logic      latch_q,
  output logic      fall_q
);
  logic pin_prev_q;
  logic fall;
  logic hold_q;
  logic hold_d;
  logic latch_d;

  // high one cycle, low the next: a falling edge
  assign fall = pin_prev_q & ~pin_n;
  // edge memory: a fresh edge wins over an ack in the same cycle
  assign hold_d = fall
                | (hold_q & ~ack);
  // level mode: a low pin keeps the request after the ack is gone,
  // so ack and pin release may come in either order
  assign latch_d = hold_d | (level_mode & ~pin_n);

  // pin history follows the pin through reset, so a pin held low
  // across reset is not taken for a fresh edge afterwards
  always_ff @(posedge sys_clk) begin
    pin_prev_q <= pin_n;
    if (reset) begin
      hold_q  <= 1'b0;
      latch_q <= 1'b0;
      fall_q  <= 1'b0;
    end else begin
      hold_q  <= hold_d;
      latch_q <= latch_d;
      fall_q  <= fall;
    end
  end
endmodule

// [epi_top.sv]
// external pin interrupt unit with axi4-lite register slave
// Functional notes
// - falling pin edge sets the request latch
// - vector fetch acknowledges and clears the latch
// - writing one to ack clears latch
// - reset clears latch and sensitivity select
// - edge only after reset, level optional
// - edge mode: latch holds until acknowledged
// - level mode: needs ack and pin high
// - local mask blocks request to priority logic
// - cpu global mask also blocks request
// - edge after ack latches fresh request
// - taken request vectors through fixed pair
// - pending flag ignores the local mask
// - pin level readable for branch tests
// - break clear enable lets ack clear
// - break without enable ignores ack writes
// - ack bit write-only, reads zero
// - pending read-only; reset clears local mask
`timescale 1ns/1ns
module epi_top (
  input  wire logic        sys_clk,
  input  wire logic        reset,
  input  wire logic        irq_pin_n,
  input  wire logic        cpu_global_mask,
  input  wire logic        vector_fetch,
  input  wire logic        break_state,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic             cpu_irq_req_q,
  output logic [15:0]      vector_addr_q,
  output logic             pin_high_q,
  output logic             irq_out_q
);
  typedef enum logic [1:0] {EPI_IDLE, EPI_RESP} epi_wr_st_t;

  epi_wr_st_t  wr_st_q;
  logic        aw_held_q;
  logic        w_held_q;
  logic [7:0]  awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0]  wstrb_q;
  logic        mode_q;
  logic        mask_q;
  logic        break_clear_enable_q;
  logic [1:0]  ev_status_q;
  logic [1:0]  ev_mask_q;
  logic        latch_q;
  logic        fall_q;
  logic        fetch_prev_q;
  logic        wr_fire;
  logic        wr_ok;
  logic        wr_scr;
  logic        wr_brk;
  logic        wr_evs;
  logic        wr_evm;
  logic        sw_ack;
  logic        fetch_ack;
  logic        ack;
  logic        rd_ok;
  logic [31:0] rd_word;
  logic [31:0] scr_word;
  logic [1:0]  ev_set;
  logic [1:0]  ev_clr;

  // byte address is one of ours when word aligned and in range
  function automatic logic addr_hit(input logic [7:0] a);
    addr_hit = (a[1:0] == 2'h0) && (a <= epi_pkg::OFF_VECTOR);
  endfunction

  epi_latch u_latch (
    .sys_clk    (sys_clk),
    .reset      (reset),
    .pin_n      (irq_pin_n),
    .level_mode (mode_q),
    .ack        (ack),
    .latch_q    (latch_q),
    .fall_q     (fall_q)
  );

  // write happens once both address and data are held
  assign wr_fire = (wr_st_q == EPI_IDLE) & aw_held_q & w_held_q;
  assign wr_ok   = addr_hit(awaddr_q);
  assign wr_scr  = wr_fire & wr_ok & (awaddr_q == epi_pkg::OFF_STATUS_CTRL)
                 & wstrb_q[0];
  assign wr_brk  = wr_fire & wr_ok & (awaddr_q == epi_pkg::OFF_BREAK_CTRL)
                 & wstrb_q[0];
  assign wr_evs  = wr_fire & wr_ok & (awaddr_q == epi_pkg::OFF_IRQ_STATUS)
                 & wstrb_q[0];
  assign wr_evm  = wr_fire & wr_ok & (awaddr_q == epi_pkg::OFF_IRQ_MASK)
                 & wstrb_q[0];

  // ack during break only counts when break clear is enabled
  assign sw_ack    = wr_scr & wdata_q[epi_pkg::BIT_ACK]
                   & (~break_state | break_clear_enable_q);
  // fetch edge of this vector is the automatic acknowledge
  assign fetch_ack = vector_fetch & ~fetch_prev_q;
  assign ack       = sw_ack | fetch_ack;

  // ack reads zero; pending shows latch whatever the mask
  assign scr_word = {28'h0000000,
                     latch_q,
                     1'b0,
                     mask_q,
                     mode_q};

  assign rd_ok = addr_hit(s_axi_araddr);
  always_comb begin
    rd_word = 32'h00000000;
    case (s_axi_araddr)
      epi_pkg::OFF_STATUS_CTRL: rd_word = scr_word;
      epi_pkg::OFF_BREAK_CTRL:  rd_word = {24'h000000, break_clear_enable_q, 7'h00};
      epi_pkg::OFF_IRQ_STATUS:  rd_word = {30'h00000000, ev_status_q};
      epi_pkg::OFF_IRQ_MASK:    rd_word = {30'h00000000, ev_mask_q};
      epi_pkg::OFF_PIN_LEVEL:   rd_word = {31'h00000000, irq_pin_n};
      epi_pkg::OFF_VECTOR:      rd_word = {16'h0000,
                                           epi_pkg::VEC_HI_ADDR};
      default:                  rd_word = 32'h00000000;
    endcase
  end

  // sticky events: a new event wins over a write-one clear
  assign ev_set = {fetch_ack, fall_q};
  assign ev_clr = wr_evs ? wdata_q[1:0] : 2'h0;

  // write channel: capture aw and w in any order, then respond
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      wr_st_q       <= EPI_IDLE;
      aw_held_q     <= 1'b0;
      w_held_q      <= 1'b0;
      awaddr_q      <= 8'h00;
      wdata_q       <= 32'h00000000;
      wstrb_q       <= 4'h0;
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= epi_pkg::RESP_OKAY;
    end else begin
      case (wr_st_q)
        EPI_IDLE: begin
          if (s_axi_awvalid & s_axi_awready) begin
            aw_held_q     <= 1'b1;
            awaddr_q      <= s_axi_awaddr;
            s_axi_awready <= 1'b0;
          end
          if (s_axi_wvalid & s_axi_wready) begin
            w_held_q     <= 1'b1;
            wdata_q      <= s_axi_wdata;
            wstrb_q      <= s_axi_wstrb;
            s_axi_wready <= 1'b0;
          end
          if (wr_fire) begin
            wr_st_q      <= EPI_RESP;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_ok ? epi_pkg::RESP_OKAY
                                  : epi_pkg::RESP_SLVERR;
          end
        end
        EPI_RESP: begin
          if (s_axi_bready) begin
            wr_st_q       <= EPI_IDLE;
            s_axi_bvalid  <= 1'b0;
            aw_held_q     <= 1'b0;
            w_held_q      <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
          end
        end
        default: wr_st_q <= EPI_IDLE;
      endcase
    end
  end

  // read channel: one cycle to answer, held until rready
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= epi_pkg::RESP_OKAY;
    end else if (s_axi_rvalid) begin
      if (s_axi_rready) begin
        s_axi_rvalid  <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end else if (s_axi_arvalid) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rdata   <= rd_ok ? rd_word : 32'h00000000;
      s_axi_rresp   <= rd_ok ? epi_pkg::RESP_OKAY : epi_pkg::RESP_SLVERR;
    end
  end

  // control bits; reset gives edge-only, unmasked, protected break
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      mode_q <= epi_pkg::RST_MODE;
      mask_q <= epi_pkg::RST_MASK;
      break_clear_enable_q <= epi_pkg::RST_BREAK_CLEAR_ENABLE;
    end else begin
      if (wr_scr) begin
        mode_q <= wdata_q[epi_pkg::BIT_MODE];
        mask_q <= wdata_q[epi_pkg::BIT_MASK];
      end
      if (wr_brk) begin
        break_clear_enable_q <= wdata_q[epi_pkg::BIT_BREAK_CLEAR_ENABLE];
      end
    end
  end

  // event status and mask for the system interrupt line
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      ev_status_q <= epi_pkg::RST_EV;
      ev_mask_q   <= epi_pkg::RST_EV;
    end else begin
      ev_status_q <= (ev_status_q & ~ev_clr) | ev_set;
      if (wr_evm) begin
        ev_mask_q <= wdata_q[1:0];
      end
    end
  end

  // cpu side: masked request, vector, pin level, event line
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      fetch_prev_q  <= 1'b0;
      cpu_irq_req_q <= 1'b0;
      vector_addr_q <= epi_pkg::VEC_HI_ADDR;
      pin_high_q    <= 1'b1;
      irq_out_q     <= 1'b0;
    end else begin
      fetch_prev_q  <= vector_fetch;
      // the mask hides only the request, the latch stays visible
      cpu_irq_req_q <= latch_q & ~mask_q
                     & ~cpu_global_mask;
      vector_addr_q <= epi_pkg::VEC_HI_ADDR;
      pin_high_q    <= irq_pin_n;
      irq_out_q     <= |(ev_status_q & ev_mask_q);
    end
  end
endmodule

// [epi_top_checker.sv]
// port assertions for the pin interrupt unit
`timescale 1ns/1ns
module epi_top_checker (
  input wire logic        sys_clk,
  input wire logic        reset,
  input wire logic        irq_pin_n,
  input wire logic        cpu_global_mask,
  input wire logic        vector_fetch,
  input wire logic        break_state,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        cpu_irq_req_q,
  input wire logic [15:0] vector_addr_q,
  input wire logic        pin_high_q,
  input wire logic        irq_out_q
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (reset);

  // past guard: the copy is forced high while reset is applied
  chk_pin_copy: assert property (
    !$past(reset) |-> pin_high_q == $past(irq_pin_n)) else $error("pin copy");
  chk_vec_fixed: assert property (
    vector_addr_q == epi_pkg::VEC_HI_ADDR) else $error("vector address");
  chk_gmask_blk: assert property (
    $past(cpu_global_mask) |-> !cpu_irq_req_q) else $error("global mask");
  chk_reset_clr: assert property (
    $past(reset) |-> !cpu_irq_req_q && !irq_out_q) else $error("reset clear");
  // pin held high so no fresh edge or level can refill the latch
  chk_fetch_clr: assert property (
    $rose(vector_fetch) && $past(irq_pin_n) ##0
    (irq_pin_n && !break_state)[*5] |-> !cpu_irq_req_q)
    else $error("fetch ack");
  chk_b_hold: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid) else $error("bvalid drop");
  chk_r_hold: assert property (
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("rvalid drop");
  chk_ack_rd0: assert property (
    s_axi_rvalid |-> !s_axi_rdata[epi_pkg::BIT_ACK]) else $error("ack reads");

  cover property ($rose(cpu_irq_req_q));
  cover property ($rose(irq_out_q));
  cover property ($rose(vector_fetch) && cpu_irq_req_q);
endmodule

// [epi_pin_dev.sv]
// external device model that pulls the interrupt pin low
`timescale 1ns/1ns
module epi_pin_dev (
  input  wire logic       sys_clk,
  input  wire logic       pull_req,
  input  wire logic [2:0] lag,
  output logic            irq_pin_n
);
  logic [2:0] wait_q = 3'h0;
  logic       low_q  = 1'b0;
  // released pin rises through the internal pullup, so it reads high
  assign irq_pin_n = !low_q;
  // answers after lag clocks; the bench draws one random lag, so one device speed is seen per run
  always @(posedge sys_clk) begin
    if (!pull_req) begin
      wait_q <= 3'h0;
      low_q  <= 1'b0;
    end else if (wait_q == lag) begin
      low_q <= 1'b1;
    end else begin
      wait_q <= wait_q + 3'h1;
    end
  end
endmodule

// [tb_top.sv]
// self-checking bench for the pin interrupt unit
`timescale 1ns/1ns
module tb_top;
  localparam logic [7:0] SC = epi_pkg::OFF_STATUS_CTRL;
  localparam logic [7:0] BC = epi_pkg::OFF_BREAK_CTRL;
  localparam logic [7:0] ES = epi_pkg::OFF_IRQ_STATUS;
  localparam logic [7:0] EM = epi_pkg::OFF_IRQ_MASK;
  logic        sys_clk, reset, cpu_global_mask, vector_fetch, break_state;
  logic        s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid;
  logic        s_axi_rready, s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic        s_axi_arready, s_axi_rvalid, cpu_irq_req_q, pin_high_q;
  logic        irq_out_q, irq_pin_n, pull_req;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, r;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [15:0] vector_addr_q;
  logic [2:0]  lag;
  logic [33:0] exp_q[$];
  logic [1:0]  bexp_q[$];
  int          n_errors, cmp_count;

  epi_top u_dut (.sys_clk, .reset, .irq_pin_n, .cpu_global_mask, .vector_fetch,
    .break_state, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .cpu_irq_req_q, .vector_addr_q,
    .pin_high_q, .irq_out_q);
  epi_pin_dev u_dev (.sys_clk, .pull_req, .lag, .irq_pin_n);

  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end

  task chk(input logic [33:0] got, input logic [33:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask

  task give_verdict;
    $display("errors %0d compares %0d", n_errors, cmp_count);
    if (n_errors == 0 && cmp_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task wt(input int n);
    repeat (n) @(posedge sys_clk);
  endtask

  // address and data offered together, each dropped once taken
  task wr(input logic [7:0] a, input logic [31:0] d,
          input logic [1:0] er = epi_pkg::RESP_OKAY);
    int i;
    @(posedge sys_clk);
    bexp_q.push_back(er);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (i = 0; i < 50; i++) begin
      @(posedge sys_clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) break;
    end
    s_axi_bready <= 1'b0;
    if (i == 50) begin
      n_errors++;
      give_verdict;
    end
  endtask

  // the expected word is noted here and compared by the monitor
  task rd(input logic [7:0] a, input logic [31:0] e,
          input logic [1:0] er = epi_pkg::RESP_OKAY);
    int i;
    @(posedge sys_clk);
    exp_q.push_back({er, e});
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (i = 0; i < 50; i++) begin
      @(posedge sys_clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) break;
    end
    s_axi_rready <= 1'b0;
    if (i == 50) begin
      n_errors++;
      give_verdict;
    end
  endtask

  // pin pulse long enough for the slowest device lag
  task pulse;
    pull_req <= 1'b1;
    wt(10);
    pull_req <= 1'b0;
    wt(4);
  endtask

  // monitor pairs each answer with the oldest note of its channel
  always @(posedge sys_clk) begin
    if (s_axi_rvalid && s_axi_rready && exp_q.size() > 0) begin
      chk({s_axi_rresp, s_axi_rdata}, exp_q.pop_front());
    end
    if (s_axi_bvalid && s_axi_bready && bexp_q.size() > 0) begin
      chk(s_axi_bresp, bexp_q.pop_front());
    end
  end

  initial begin
    {reset, cpu_global_mask, vector_fetch, break_state, pull_req} = 5'h10;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
    {s_axi_arvalid, s_axi_rready, lag, s_axi_wstrb} = 9'h00f;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
    void'($urandom(32'h689ea129));
    wt(3);
    reset <= 1'b0;
    rd(SC, 32'h0);
    rd(BC, 32'h0);
    rd(epi_pkg::OFF_VECTOR, 32'hfffa);
    rd(epi_pkg::OFF_PIN_LEVEL, 32'h1);
    rd(8'h40, 32'h0, epi_pkg::RESP_SLVERR);
    wr(8'h41, 32'h0, epi_pkg::RESP_SLVERR);
    lag <= 3'($urandom);
    pulse;
    rd(SC, 32'h8);
    chk(cpu_irq_req_q, 1);
    cpu_global_mask <= 1'b1;
    wt(3);
    chk(cpu_irq_req_q, 0);
    cpu_global_mask <= 1'b0;
    wr(SC, 32'h2);
    wt(2);
    chk(cpu_irq_req_q, 0);
    rd(SC, 32'ha);
    wr(SC, 32'h0);
    wt(2);
    chk(cpu_irq_req_q, 1);
    wr(SC, 32'h4);
    rd(SC, 32'h0);
    pulse;
    rd(SC, 32'h8);
    vector_fetch <= 1'b1;
    wt(2);
    vector_fetch <= 1'b0;
    wt(2);
    rd(SC, 32'h0);
    rd(ES, 32'h3);
    // level mode, ack while low then release; handler masks meanwhile
    wr(SC, 32'h1);
    pull_req <= 1'b1;
    wt(10);
    wr(SC, 32'h7);
    wt(3);
    rd(SC, 32'hb);
    pull_req <= 1'b0;
    wt(4);
    rd(SC, 32'h3);
    pulse;
    rd(SC, 32'hb);
    wr(SC, 32'h7);
    rd(SC, 32'h3);
    // reset in mid-run with the pin still low
    pull_req <= 1'b1;
    wt(10);
    reset <= 1'b1;
    wt(3);
    reset <= 1'b0;
    rd(SC, 32'h0);
    pull_req <= 1'b0;
    wt(4);
    break_state <= 1'b1;
    pulse;
    wr(SC, 32'h4);
    rd(SC, 32'h8);
    wr(BC, 32'h80);
    wr(SC, 32'h4);
    rd(SC, 32'h0);
    break_state <= 1'b0;
    wt(2);
    rd(SC, 32'h0);
    wr(ES, 32'h3);
    wr(EM, 32'h1);
    pulse;
    chk(irq_out_q, 1);
    rd(ES, 32'h1);
    wr(EM, 32'h0);
    wt(2);
    chk(irq_out_q, 0);
    wr(ES, 32'h1);
    rd(ES, 32'h0);
    repeat (4) begin
      r = $urandom;
      wr(EM, r);
      rd(EM, r & 32'h3);
    end
    wt(3);
    give_verdict;
  end
endmodule

bind epi_top epi_top_checker u_chk (.sys_clk, .reset, .irq_pin_n,
  .cpu_global_mask, .vector_fetch, .break_state, .s_axi_bvalid, .s_axi_bready,
  .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .cpu_irq_req_q, .vector_addr_q,
  .pin_high_q, .irq_out_q);
